//--- rtl/pml_port.sv
/*
 * one port of mii logic: clocks, tx capture, rx framing, crs/col, loopback,
 * strap based startup and a small register port.
 * assumes a line decoder on core_clk delivering symbols and a mac on the mii.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R01: at reset straps are read; unforced ports run negotiation or parallel detect
// R02: a parallel detected link is always half duplex
// R03: two bit crossover field, automatic crossover after reset
// R04: fiber chosen only by config bit or strap, never by negotiation
// R05: idle symbols at 100, link pulses at 10 while no data
// R06: device drives tx and rx mii clocks, 25 mhz or 2.5 mhz
// R07: tx data and control captured on rising tx clock
// R08: mac raises tx enable with preamble, drops after last bit
// R09: at 100 rx valid spans preamble through last data nibble
// R10: at 10 preamble dropped, rx valid from first sfd nibble
// R11: crs on receive always, on transmit only in half duplex
// R12: at 100 crs rises on j/k and falls on t/r
// R13: idle without t/r drops crs and pulses rx error one cycle
// R14: at 10 crs follows valid preamble until end of frame
// R15: invalid symbol at 100 gives rx error and nibble 1110
// R16: tx error from mac sends halt symbols on the line
// R17: col when half duplex with tx and rx both active
// R18: 10 half duplex echo of tx data unless echo disable set
// R19: test loopback disables line and returns tx data to rx
// R20: test loopback needs loop set, full duplex, negotiation off
// R21: mii moves four bit nibbles with their control signals
// R22: duplex strap high gives full duplex default
// R23: rate strap high gives 100 mbps default
// R24: this module is instanced once per port
module pml_port (
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              rate_strap_pin,
    input  wire logic              half_full_strap_pin,
    input  wire logic              aneg_strap_pin,
    input  wire logic              fiber_strap_n_pin,
    input  wire pml_pkg::pml_tx_t  mii_tx,
    input  wire pml_pkg::pml_sym_t line_sym,
    input  wire logic [3:0]        line_nibble,
    input  wire logic              line_sym_stb,
    input  wire logic              an_done,
    input  wire logic              an_full,
    input  wire logic              an_fast,
    input  wire logic              pd_done,
    input  wire logic              pd_fast,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    output logic                   tx_clk,
    output logic                   rx_clk,
    output pml_pkg::pml_rx_t       mii_rx,
    output pml_pkg::pml_ltx_t      line_tx,
    output logic [3:0]             line_tx_nibble,
    output logic                   line_en,
    output logic [1:0]             crossover_select,
    output logic                   fiber_sel
);
    import pml_pkg::*;

    function automatic logic [15:0] strip(input logic [15:0] v, input int b);
        strip = 16'(v[b]) << b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strap capture and control registers
    logic        strap_s1_q, strap_s2_q, strap_done_q;
    logic [3:0]  pin1_q, pin2_q;
    logic [15:0] ctl_q, cfg_q;
    logic [1:0]  xo_q;
    logic        speed100_q, full_q, linked_q;

    // no snapshot under reset: straps are sampled after release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_q       <= 4'h0;
            pin2_q       <= 4'h0;
            strap_done_q <= 1'b0;
        end else begin
            pin1_q       <= {rate_strap_pin, half_full_strap_pin,
                             aneg_strap_pin, fiber_strap_n_pin};
            pin2_q       <= pin1_q;
            strap_done_q <= strap_s2_q;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= 1'b1;
            strap_s2_q <= strap_s1_q;
        end
    end
    wire strap_load = strap_s2_q && !strap_done_q;

    wire sel_ctl = reg_addr == OFS_CONTROL;
    wire sel_cfg = reg_addr == OFS_PORTCFG;
    wire sel_xo  = reg_addr == OFS_XOVER;
    wire sel_st  = reg_addr == OFS_STATUS;
    wire aneg_on = ctl_q[CTL_ANEG_BIT];

    // R01 R22 R23 strap defaults
    wire [15:0] ctl_strap = strip({2'h0, pin2_q[3], 4'h0, pin2_q[2], 8'h0},
                                  CTL_SPEED_BIT)
                          | strip({3'h0, pin2_q[1], 12'h0}, CTL_ANEG_BIT)
                          | strip({7'h0, pin2_q[2], 8'h0}, CTL_DUPLEX_BIT);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= 16'h0000;
            cfg_q <= CFG_RESET;
            xo_q  <= XO_RESET;
        end else if (strap_load) begin
            ctl_q <= ctl_strap;
            // R04 fiber from strap here, or later from a port config write
            cfg_q <= {cfg_q[15:1], ~pin2_q[0]};
        end else if (reg_wr) begin
            if (sel_ctl) ctl_q <= reg_wdata;
            if (sel_cfg) cfg_q <= reg_wdata;
            // R03 crossover field
            if (sel_xo)  xo_q  <= reg_wdata[XO_LSB +: 2];
        end
    end

    // R01 R02 operating mode resolution
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed100_q <= 1'b0;
            full_q     <= 1'b0;
            linked_q   <= 1'b0;
        end else if (!aneg_on) begin
            speed100_q <= ctl_q[CTL_SPEED_BIT] || cfg_q[CFG_FIBER_BIT];
            full_q     <= ctl_q[CTL_DUPLEX_BIT];
            linked_q   <= strap_done_q;
        end else if (an_done) begin
            speed100_q <= an_fast;
            full_q     <= an_full;
            linked_q   <= 1'b1;
        end else if (pd_done) begin
            speed100_q <= pd_fast;
            full_q     <= 1'b0;
            linked_q   <= 1'b1;
        end
    end

    // R20 test loopback condition
    wire test_loop = ctl_q[CTL_LOOP_BIT] && ctl_q[CTL_DUPLEX_BIT] && !aneg_on;
    // R18 operational echo condition
    wire op_echo = !speed100_q && !full_q && !cfg_q[CFG_NOECHO_BIT];

    wire [15:0] status_word = {12'h000, test_loop, full_q, speed100_q,
                               linked_q};
    wire [15:0] rd_mux = sel_ctl ? ctl_q :
                         sel_cfg ? cfg_q :
                         sel_xo  ? {6'h00, xo_q, 8'h00} :
                         sel_st  ? status_word : 16'h0000;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= 16'h0000;
        else        reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // R06 mii clock generation
    logic [8:0] div_q;
    logic       mclk_q;
    wire [8:0]  half = speed100_q ? 9'(HALF100_CYC - 1) : 9'(HALF10_CYC - 1);
    wire        div_end = div_q >= half;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 9'h000;
            mclk_q <= 1'b0;
        end else begin
            div_q  <= div_end ? 9'h000 : div_q + 9'h001;
            mclk_q <= div_end ? ~mclk_q : mclk_q;
        end
    end
    wire mclk_rise = div_end && !mclk_q;
    assign tx_clk = mclk_q;
    assign rx_clk = mclk_q;

    ////////////////////////////////////////////////////////////////////////
    // R07 R21 tx capture on tx clock rise
    pml_tx_t tx_s1_q, tx_s2_q, tx_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_s1_q <= '0;
            tx_s2_q <= '0;
            tx_q    <= '0;
        end else begin
            tx_s1_q <= mii_tx;
            tx_s2_q <= tx_s1_q;
            // R08 tx enable framing comes from the mac
            if (mclk_rise) tx_q <= tx_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // line transmit
    logic [13:0] nlp_q;
    wire nlp_due = nlp_q == 14'(NLP_CYC - 1);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) nlp_q <= 14'h0000;
        else        nlp_q <= nlp_due ? 14'h0000 : nlp_q + 14'h0001;
    end
    // R19 line off in test loopback; R16 halt on tx error; R05 fill
    wire pml_ltx_t ltx_d = test_loop        ? LTX_OFF  :
                           tx_q.tx_er       ? LTX_HALT :
                           tx_q.tx_en       ? LTX_DATA :
                           speed100_q       ? LTX_IDLE :
                           nlp_due          ? LTX_NLP  : LTX_OFF;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_tx        <= LTX_OFF;
            line_tx_nibble <= 4'h0;
            line_en        <= 1'b0;
            crossover_select <= XO_RESET;
            fiber_sel      <= 1'b0;
        end else begin
            line_tx        <= ltx_d;
            line_tx_nibble <= tx_q.txd;
            line_en        <= !test_loop;
            crossover_select <= xo_q;
            fiber_sel      <= cfg_q[CFG_FIBER_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive framing
    logic       rcv_q, dv_q, err_q, sfd_q;
    logic [3:0] rnib_q;
    wire sym_end  = line_sym == SYM_TR || line_sym == SYM_EOF;
    wire start    = speed100_q ? line_sym == SYM_JK : line_sym == SYM_PRE;
    // R13 idle without end delimiter
    wire bad_end  = speed100_q && rcv_q && line_sym == SYM_IDLE;
    // preamble nibbles are also 5, so only a data-class 5 opens the frame
    wire sfd_sym  = line_sym == SYM_DATA && line_nibble == SFD_FIRST;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rcv_q  <= 1'b0;
            dv_q   <= 1'b0;
            err_q  <= 1'b0;
            sfd_q  <= 1'b0;
            rnib_q <= 4'h0;
        end else if (test_loop) begin
            rcv_q  <= 1'b0;
            dv_q   <= 1'b0;
            err_q  <= 1'b0;
            sfd_q  <= 1'b0;
        end else if (line_sym_stb) begin
            // R12 R14 carrier from start to end marker
            rcv_q <= (rcv_q || start) && !sym_end && !bad_end;
            // R15 invalid symbol substitution
            err_q  <= bad_end || (speed100_q && line_sym == SYM_BAD);
            rnib_q <= (speed100_q && line_sym == SYM_BAD) ? ERR_NIBBLE
                                                          : line_nibble;
            // R10 wait for first sfd nibble at 10
            if (!rcv_q || sym_end) sfd_q <= 1'b0;
            else if (sfd_sym) sfd_q <= 1'b1;
            // R09 valid across preamble at 100
            dv_q <= rcv_q && !sym_end && !bad_end && (speed100_q ? 1'b1 :
                    (sfd_q || sfd_sym));
        end else if (mclk_rise) begin
            // R13 error pulse ends at the next rx clock rise
            err_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mii receive outputs, loopback selection, crs and col
    wire loop_sel = test_loop || (op_echo && tx_q.tx_en && !rcv_q);
    // R11 crs on receive, transmit only half duplex
    // test loopback is full duplex, so its transmit raises no carrier
    wire crs_d = rcv_q || (tx_q.tx_en && !full_q);
    // R17 collision only in half duplex
    wire col_d = !full_q && tx_q.tx_en && rcv_q;
    // R18 R19 loop tx onto rx path
    pml_rx_t rx_d;
    assign rx_d.rxd   = loop_sel ? tx_q.txd   : rnib_q;
    assign rx_d.rx_dv = loop_sel ? tx_q.tx_en : dv_q;
    assign rx_d.rx_er = loop_sel ? tx_q.tx_er : err_q;
    assign rx_d.crs   = crs_d;
    assign rx_d.col   = col_d;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) mii_rx <= '0;
        else        mii_rx <= rx_d;
    end
    // R24 instanced once per port by the chip top
endmodule
`default_nettype wire

//--- rtl/pml_pkg.sv
/*
 * shared constants and carrier types for the per-port mii logic.
 * assumes one core clock of 250 mhz and a register port on the same clock.
 */
package pml_pkg;
    localparam int          CORE_MHZ        = 250;
    localparam int          MII100_KHZ      = 25000;
    localparam int          MII10_KHZ       = 2500;
    // half period of the mii clocks in core cycles
    localparam int          HALF100_CYC     = CORE_MHZ * 1000 / MII100_KHZ / 2;
    localparam int          HALF10_CYC      = CORE_MHZ * 1000 / MII10_KHZ / 2;
    localparam int          NLP_US          = 16;
    localparam int          NLP_CYC         = NLP_US * CORE_MHZ;
    localparam logic [3:0]  ERR_NIBBLE      = 4'hE;
    localparam logic [3:0]  SFD_FIRST       = 4'h5;
    // register offsets (word index == byte offset / 4)
    localparam logic [7:0]  OFS_CONTROL     = 8'h00;
    localparam logic [7:0]  OFS_PORTCFG     = 8'h40;
    localparam logic [7:0]  OFS_XOVER       = 8'h6C;
    localparam logic [7:0]  OFS_STATUS      = 8'h04;
    // register field positions and reset values
    localparam int          CTL_LOOP_BIT    = 14;
    localparam int          CTL_SPEED_BIT   = 13;
    localparam int          CTL_ANEG_BIT    = 12;
    localparam int          CTL_DUPLEX_BIT  = 8;
    localparam int          CFG_NOECHO_BIT  = 8;
    localparam int          CFG_FIBER_BIT   = 0;
    localparam int          XO_LSB          = 8;
    localparam logic [1:0]  XO_RESET        = 2'h2;
    localparam logic [15:0] CFG_RESET       = 16'h0000;

    typedef struct packed {
        logic [3:0] txd;
        logic       tx_en;
        logic       tx_er;
    } pml_tx_t;

    typedef struct packed {
        logic [3:0] rxd;
        logic       rx_dv;
        logic       rx_er;
        logic       crs;
        logic       col;
    } pml_rx_t;

    // symbols as delivered by the line decoder
    typedef enum logic [2:0] {
        SYM_IDLE, SYM_JK, SYM_DATA, SYM_TR, SYM_BAD, SYM_PRE, SYM_EOF
    } pml_sym_t;

    // line transmit symbols
    typedef enum logic [2:0] {
        LTX_IDLE, LTX_DATA, LTX_HALT, LTX_NLP, LTX_OFF
    } pml_ltx_t;
endpackage

//--- verification/pml_props.sv
/* port checker for one mii port.
   bound from tb onto pml_port; sees port signals only. */
`timescale 1ns/1ps
`default_nettype none
module pml_props
    import pml_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst_n,
    input wire pml_pkg::pml_tx_t  mii_tx,
    input wire pml_pkg::pml_sym_t line_sym,
    input wire logic              line_sym_stb,
    input wire logic              tx_clk,
    input wire logic              rx_clk,
    input wire pml_pkg::pml_rx_t  mii_rx,
    input wire pml_pkg::pml_ltx_t line_tx,
    input wire logic              line_en,
    input wire logic [1:0]        crossover_select
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // age of the last tx error; saturates so it never wraps
    logic [7:0] er_age_q;
    logic [7:0] er_age_d;
    assign er_age_d = mii_tx.tx_er ? 8'h00 :
        (er_age_q == 8'hFF) ? er_age_q : er_age_q + 8'h01;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            er_age_q <= 8'hFF;
        end else begin
            er_age_q <= er_age_d;
        end
    end
    sequence sym_in(pml_sym_t s);
        line_en && line_sym_stb && line_sym == s;
    endsequence
    sequence rx_abort;
        mii_rx.crs ##0 sym_in(SYM_IDLE);
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_clk_pair: assert property (tx_clk == rx_clk)
        else $error("mii clocks differ");
    a_clk_half: assert property ($changed(tx_clk) |=> $stable(tx_clk)[*4])
        else $error("mii clock half period too short");
    a_xover_init: assert property ($rose(rst_n) |-> crossover_select == XO_RESET)
        else $error("crossover not automatic after reset");
    a_jk_carrier: assert property (sym_in(SYM_JK) |-> ##2 mii_rx.crs)
        else $error("carrier missing after start of stream");
    a_bad_nibble: assert property (sym_in(SYM_BAD) |-> ##2
        mii_rx.rx_er && mii_rx.rxd == ERR_NIBBLE)
        else $error("bad symbol not flagged");
    a_idle_abort: assert property (rx_abort |-> ##2
        (!mii_rx.crs && mii_rx.rx_er))
        else $error("idle abort not flagged");
    a_col_carrier: assert property (mii_rx.col |-> mii_rx.crs)
        else $error("collision without carrier");
    a_halt_cause: assert property (line_tx == LTX_HALT |-> er_age_q < 8'd120)
        else $error("halt without tx error");
endmodule
`default_nettype wire

//--- verification/pml_mac_model.sv
/* mac model driving the mii transmit side of one port.
   assumes tx_clk comes from the port and is sampled on core_clk. */
`timescale 1ns/1ps
`default_nettype none
module pml_mac_model
    import pml_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       tx_clk,
    input  wire logic       start,
    input  wire logic [7:0] len,
    input  wire logic       err,
    output pml_pkg::pml_tx_t mii_tx,
    output logic            busy
);
    logic       clk_q;
    logic [7:0] idx_q;
    wire        rise = tx_clk && !clk_q;
    wire  [3:0] nib = (idx_q < 8'd15) ? 4'h5 :
        (idx_q == 8'd15) ? 4'hD : idx_q[3:0] ^ 4'h6;
    ////////////////////////////////////////////////////////////////////
    // change just after tx clock rise, enable with preamble
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
            idx_q <= 8'h00;
            busy <= 1'b0;
            mii_tx <= '0;
        end else begin
            clk_q <= tx_clk;
            if (start) begin
                busy <= 1'b1;
            end else if (rise && busy && idx_q == len) begin
                // released lines show the inverse, not a stale nibble
                busy <= 1'b0;
                idx_q <= 8'h00;
                mii_tx <= '{txd: ~mii_tx.txd, tx_en: 1'b0, tx_er: 1'b0};
            end else if (rise && busy) begin
                idx_q <= idx_q + 8'h01;
                mii_tx <= '{txd: nib, tx_en: 1'b1, tx_er: err && idx_q > 8'd20};
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
/* self-checking bench for one mii port.
   assumes pml_props and pml_mac_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pml_pkg::*;
    logic core_clk = 0, rst_n = 0, start = 0, err = 0, busy;
    logic reg_wr = 0, reg_rd = 0, line_sym_stb = 0, tck_q, rck_q;
    logic tx_clk, rx_clk, line_en, fiber_sel;
    logic an_done = 0, an_full = 0, an_fast = 0, pd_done = 0, pd_fast = 0;
    logic [7:0] reg_addr = 0, len = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, d, c;
    logic [3:0] line_nibble = 0, line_tx_nibble;
    logic [1:0] crossover_select;
    pml_sym_t line_sym = SYM_IDLE;
    pml_ltx_t line_tx;
    pml_tx_t mii_tx;
    pml_rx_t mii_rx;
    int error_cnt = 0, checked = 0, cyc = 0;
    logic [31:0] seed = 32'd75;
    logic [3:0] txq[$], rxq[$];
    bit saw_halt, saw_col;
    pml_sym_t rx_seq[12] = '{SYM_JK, SYM_DATA, SYM_DATA, SYM_DATA, SYM_TR,
        SYM_IDLE, SYM_JK, SYM_DATA, SYM_BAD, SYM_DATA, SYM_IDLE, SYM_IDLE};
    pml_sym_t col_seq[6] = '{SYM_JK, SYM_DATA, SYM_DATA, SYM_DATA,
        SYM_DATA, SYM_TR};
    pml_port u_dut (.core_clk(core_clk), .rst_n(rst_n), .rate_strap_pin(1'b1),
        .half_full_strap_pin(1'b0), .aneg_strap_pin(1'b0),
        .fiber_strap_n_pin(1'b1), .mii_tx(mii_tx), .line_sym(line_sym),
        .line_nibble(line_nibble), .line_sym_stb(line_sym_stb),
        .an_done(an_done), .an_full(an_full), .an_fast(an_fast),
        .pd_done(pd_done), .pd_fast(pd_fast), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_clk(tx_clk), .rx_clk(rx_clk), .mii_rx(mii_rx),
        .line_tx(line_tx), .line_tx_nibble(line_tx_nibble),
        .line_en(line_en), .crossover_select(crossover_select),
        .fiber_sel(fiber_sel));
    pml_mac_model u_mac (.core_clk(core_clk), .rst_n(rst_n), .tx_clk(tx_clk),
        .start(start), .len(len), .err(err), .mii_tx(mii_tx), .busy(busy));
    function automatic logic [31:0] xs(logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic [15:0] loop_exp(logic [15:0] v);
        return {12'h0, v[14] & v[8] & ~v[12], 3'h0};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic sym(input pml_sym_t s);
        @(posedge core_clk);
        line_sym <= s;
        line_nibble <= seed[3:0];
        line_sym_stb <= 1'b1;
        seed = xs(seed);
        @(posedge core_clk);
        line_sym_stb <= 1'b0;
        repeat (2 * HALF100_CYC - 2) @(posedge core_clk);
    endtask
    task automatic frame(input logic [7:0] n, input logic e);
        @(posedge core_clk);
        len <= n;
        err <= e;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        for (int i = 0; i < 4000 && (busy || i < 2); i++) @(posedge core_clk);
        repeat (60) @(posedge core_clk);
    endtask
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        tck_q <= tx_clk;
        rck_q <= rx_clk;
        cyc <= cyc + 1;
        if (tx_clk && !tck_q && mii_tx.tx_en) txq.push_back(mii_tx.txd);
        if (rx_clk && !rck_q && mii_rx.rx_dv) rxq.push_back(mii_rx.rxd);
        if (line_tx == LTX_HALT) saw_halt <= 1'b1;
        if (mii_rx.col) saw_col <= 1'b1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        rd(OFS_XOVER, d);
        chk(d, {6'h00, XO_RESET, 8'h00});
        rd(8'h20, d);
        chk(d, 16'h0000);
        rd(OFS_STATUS, d);
        chk(d & 16'h0006, 16'h0002);
        rd(OFS_CONTROL, d);
        chk(d & 16'h3100, 16'h2000);
        chk({15'h0, fiber_sel}, 16'h0000);
        wr(OFS_PORTCFG, 16'h0001);
        @(posedge core_clk);
        #1 chk({15'h0, fiber_sel}, 16'h0001);
        $display("test registers done");
        for (int i = 0; i < 9; i++) begin
            c = (i == 8) ? 16'h6100 : seed[15:0] & 16'h7100;
            seed = xs(seed);
            wr(OFS_CONTROL, c);
            rd(OFS_STATUS, d);
            chk(d & 16'h0008, loop_exp(c));
        end
        txq.delete();
        rxq.delete();
        frame(8'd40, 1'b0);
        chk({15'h0, line_en}, 16'h0000);
        chk(16'(rxq.size()), 16'(txq.size()));
        foreach (txq[i]) if (i < rxq.size()) chk(16'(rxq[i]), 16'(txq[i]));
        $display("test loopback done");
        wr(OFS_CONTROL, 16'h2100);
        foreach (rx_seq[i]) begin
            sym(rx_seq[i]);
            if (rx_seq[i] == SYM_TR) chk({15'h0, mii_rx.crs}, 16'h0000);
        end
        saw_halt = 1'b0;
        frame(8'd30, 1'b1);
        chk({15'h0, saw_halt}, 16'h0001);
        $display("test receive and halt done");
        for (int f = 0; f < 2; f++) begin
            wr(OFS_CONTROL, f ? 16'h2100 : 16'h2000);
            saw_col = 1'b0;
            fork
                frame(8'd60, 1'b0);
                foreach (col_seq[j]) sym(col_seq[j]);
            join
            chk({15'h0, saw_col}, f ? 16'h0000 : 16'h0001);
        end
        $display("test collision done");
        wr(OFS_PORTCFG, 16'h0000);
        wr(OFS_CONTROL, 16'h0000);
        txq.delete();
        rxq.delete();
        frame(8'd20, 1'b0);
        // the echo trails the mac by one slow tx clock
        repeat (200) @(posedge core_clk);
        chk(16'(rxq.size()), 16'(txq.size()));
        foreach (txq[i]) if (i < rxq.size()) chk(16'(rxq[i]), 16'(txq[i]));
        $display("test echo done");
        wr(OFS_CONTROL, 16'h1000);
        an_full <= 1'b1;
        pd_fast <= 1'b1;
        pd_done <= 1'b1;
        @(posedge core_clk);
        pd_done <= 1'b0;
        rd(OFS_STATUS, d);
        chk(d & 16'h0007, 16'h0003);
        @(posedge core_clk);
        an_done <= 1'b1;
        @(posedge core_clk);
        an_done <= 1'b0;
        rd(OFS_STATUS, d);
        chk(d & 16'h0007, 16'h0005);
        chk({15'h0, fiber_sel}, 16'h0000);
        $display("test negotiation done");
        conclude();
    end
endmodule
bind pml_port pml_props u_props (.core_clk(core_clk), .rst_n(rst_n),
    .mii_tx(mii_tx), .line_sym(line_sym), .line_sym_stb(line_sym_stb),
    .tx_clk(tx_clk), .rx_clk(rx_clk), .mii_rx(mii_rx), .line_tx(line_tx),
    .line_en(line_en), .crossover_select(crossover_select));
`default_nettype wire
